//--- design/ber_pkg.sv
// Package for the lane pattern error checker: register map, fields, types.
// Assumes an 8-bit register port and one clock for bus and lane words.
package ber_pkg;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int CNT_W    = 24;
  localparam int SNAP_W   = 40;
  localparam int LANE_MAX = 8;
  localparam int SEL_W    = 3;
  localparam int PAT_W    = 2;
  localparam int SNAP_N   = SNAP_W / DATA_W;
  localparam int CNT_N    = CNT_W / DATA_W;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] A_TEST_EN  = 10'h315;
  localparam logic [ADDR_W-1:0] A_CTRL     = 10'h316;
  localparam logic [ADDR_W-1:0] A_THR_LO   = 10'h317;
  localparam logic [ADDR_W-1:0] A_THR_MID  = 10'h318;
  localparam logic [ADDR_W-1:0] A_THR_HI   = 10'h319;
  localparam logic [ADDR_W-1:0] A_CNT_LO   = 10'h31A;
  localparam logic [ADDR_W-1:0] A_CNT_MID  = 10'h31B;
  localparam logic [ADDR_W-1:0] A_CNT_HI   = 10'h31C;
  localparam logic [ADDR_W-1:0] A_PASS     = 10'h31D;
  localparam logic [ADDR_W-1:0] A_CAP      = 10'h31E;
  localparam logic [ADDR_W-1:0] A_SNAP0    = 10'h31F;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 10'h324;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 10'h325;

  // Field positions
  localparam int EN_BIT       = 0;
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_PAT_LO  = 2;
  localparam int CTRL_SEL_LO  = 4;
  localparam int CAP_REQ_BIT  = 0;
  localparam int CAP_MODE_BIT = 1;
  localparam int CAP_SEL_LO   = 2;

  // Writable bit masks and reset values
  localparam logic [DATA_W-1:0] CTRL_WMASK = 8'h7F;
  localparam logic [DATA_W-1:0] CAP_WMASK  = 8'h1F;
  localparam logic [DATA_W-1:0] REG_RST    = 8'h00;
  localparam logic [DATA_W-1:0] PASS_RST   = 8'hFF;

  // Feedback taps, as delays in bits of the serial stream
  localparam int TAP7_A  = 7;
  localparam int TAP7_B  = 6;
  localparam int TAP15_A = 15;
  localparam int TAP15_B = 14;
  localparam int TAP31_A = 31;
  localparam int TAP31_B = 28;

  typedef enum logic [1:0] {
    PAT_7    = 2'b00,
    PAT_15   = 2'b01,
    PAT_31   = 2'b10,
    PAT_NONE = 2'b11
  } pattern_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PRIME = 2'b01,
    ST_CHECK = 2'b10
  } test_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;
endpackage

//--- design/lane_ber_checker.sv
// Per-lane pseudo-random pattern error checker with lane snapshot capture.
// Assumes lane words arrive on clk_in, first serial bit in bit 0, and a bus
// master that keeps read and write strobes one cycle long.
`timescale 1ns/1ps
module lane_ber_checker #(
  parameter int LANES  = 8,
  parameter int WORD_W = 40
) (
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_n_in,
  input  wire ber_pkg::bus_req_t                      bus_in,
  input  wire logic [LANES-1:0][WORD_W-1:0]           lane_data_in,
  output logic      [ber_pkg::DATA_W-1:0]             rd_data_out,
  output logic                                        irq_out
);
  import ber_pkg::*;

  localparam int PC_W = $clog2(WORD_W + 1);

  // Refuse sizes the logic cannot serve at elaboration: the selectors are three
  // bits wide and the widest feedback tap reaches 31 bits into the previous word
  if (LANES < 1 || LANES > LANE_MAX || WORD_W < TAP31_A + 1 || WORD_W > SNAP_W) begin : g_param_check
    $error("lane_ber_checker: unsupported LANES or WORD_W");
  end

  // Self-synchronising check: every bit is predicted from the bits before it
  function automatic logic [WORD_W-1:0] prbs_err(input logic [WORD_W-1:0] prev,
                                                 input logic [WORD_W-1:0] cur,
                                                 input pattern_t          pat);
    logic [2*WORD_W-1:0] s;
    int                  a;
    int                  b;
    s = {cur, prev};
    prbs_err = '0;
    case (pat)
      PAT_7: begin
        a = TAP7_A;
        b = TAP7_B;
      end
      PAT_15: begin
        a = TAP15_A;
        b = TAP15_B;
      end
      default: begin
        a = TAP31_A;
        b = TAP31_B;
      end
    endcase
    if (pat != PAT_NONE) begin
      for (int i = 0; i < WORD_W; i++) begin
        prbs_err[i] = s[WORD_W+i] ^ s[WORD_W+i-a] ^ s[WORD_W+i-b];
      end
    end
  endfunction

  function automatic logic [PC_W-1:0] count_ones(input logic [WORD_W-1:0] v);
    count_ones = '0;
    for (int i = 0; i < WORD_W; i++) begin
      count_ones = count_ones + PC_W'(v[i]);
    end
  endfunction

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] cnt,
                                               input logic [PC_W-1:0]  add);
    logic [CNT_W:0] sum;
    sum = {1'b0, cnt} + (CNT_W+1)'(add);
    sat_add = sum[CNT_W] ? '1 : sum[CNT_W-1:0];
  endfunction

  // Register file state
  logic [DATA_W-1:0] test_en_r, test_en_nxt;
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0]  thr_r, thr_nxt;
  logic [DATA_W-1:0] cap_r, cap_nxt;
  logic [DATA_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [DATA_W-1:0] irq_mask_r, irq_mask_nxt;

  // Checker state
  test_state_t                   state_r, state_nxt;
  logic [LANES-1:0][WORD_W-1:0]  prev_r, prev_nxt;
  logic [CNT_W-1:0]              cnt_r [LANES];
  logic [CNT_W-1:0]              cnt_nxt [LANES];
  logic [DATA_W-1:0]             pass_r, pass_nxt;
  logic [SNAP_W-1:0]             snap_r, snap_nxt;
  logic [DATA_W-1:0]             rd_data_nxt;
  logic                          irq_nxt;

  // Decoded controls
  logic              wr_hit;
  logic              checker_clock_enable;
  logic              checker_run;
  logic              checker_clear;
  pattern_t          pattern_select;
  logic [SEL_W-1:0]  count_lane_select;
  logic [SEL_W-1:0]  capture_lane_select;
  logic              capture_trigger_mode;
  logic              capture_request_rise;
  logic [LANES-1:0]  lane_err_hit;
  logic [CNT_W-1:0]  count_sel;

  assign wr_hit               = bus_in.wr;
  assign checker_clock_enable = test_en_r[EN_BIT];
  assign checker_run          = ctrl_r[CTRL_RUN_BIT];
  assign checker_clear        = ctrl_r[CTRL_CLR_BIT];
  assign pattern_select       = pattern_t'(ctrl_r[CTRL_PAT_LO +: PAT_W]);
  assign count_lane_select    = ctrl_r[CTRL_SEL_LO +: SEL_W];
  assign capture_lane_select  = cap_r[CAP_SEL_LO +: SEL_W];
  assign capture_trigger_mode = cap_r[CAP_MODE_BIT];
  // Rising edge is taken from the written value against the stored one
  assign capture_request_rise = cap_nxt[CAP_REQ_BIT] & ~cap_r[CAP_REQ_BIT];

  // Selected lane count; lanes beyond LANES read as zero
  always_comb begin
    count_sel = '0;
    for (int l = 0; l < LANES; l++) begin
      if (count_lane_select == SEL_W'(l)) begin
        count_sel = cnt_r[l];
      end
    end
  end

  // Software writes; reserved bits of CTRL and CAP are masked off so they read zero
  always_comb begin
    test_en_nxt  = test_en_r;
    ctrl_nxt     = ctrl_r;
    thr_nxt      = thr_r;
    cap_nxt      = cap_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_hit) begin
      case (bus_in.addr)
        A_TEST_EN:  test_en_nxt = bus_in.wdata;
        A_CTRL:     ctrl_nxt = bus_in.wdata & CTRL_WMASK;
        A_THR_LO:   thr_nxt[0*DATA_W +: DATA_W] = bus_in.wdata;
        A_THR_MID:  thr_nxt[1*DATA_W +: DATA_W] = bus_in.wdata;
        A_THR_HI:   thr_nxt[2*DATA_W +: DATA_W] = bus_in.wdata;
        A_CAP:      cap_nxt = bus_in.wdata & CAP_WMASK;
        A_IRQ_MASK: irq_mask_nxt = bus_in.wdata;
        default:    ;
      endcase
    end
  end

  // Test state machine: one word of history is needed before any check
  always_comb begin
    state_nxt = state_r;
    if (checker_clear) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (checker_run && checker_clock_enable) begin
            state_nxt = ST_PRIME;
          end
        end
        ST_PRIME: begin
          state_nxt = ST_CHECK;
        end
        ST_CHECK: begin
          if (!checker_run || !checker_clock_enable) begin
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // Lane checkers; a disabled checker keeps its history, as a gated clock would
  always_comb begin
    logic [WORD_W-1:0] errs;
    errs         = '0;
    prev_nxt     = prev_r;
    pass_nxt     = pass_r;
    lane_err_hit = '0;
    for (int l = 0; l < LANES; l++) begin
      cnt_nxt[l] = cnt_r[l];
      if (checker_clear) begin
        cnt_nxt[l] = '0;
        pass_nxt[l] = 1'b1;
      end else if (checker_clock_enable) begin
        prev_nxt[l] = lane_data_in[l];
        errs = prbs_err(prev_r[l], lane_data_in[l], pattern_select);
        if (state_r == ST_CHECK && checker_run) begin
          lane_err_hit[l] = |errs;
          cnt_nxt[l] = sat_add(cnt_r[l], count_ones(errs));
        end
        if (cnt_r[l] > thr_r) begin
          pass_nxt[l] = 1'b0;
        end
      end
    end
  end

  // Snapshot capture of one lane word
  // A narrower lane word is zero-extended into the 40-bit snapshot
  always_comb begin
    snap_nxt = snap_r;
    for (int l = 0; l < LANES; l++) begin
      if (capture_lane_select == SEL_W'(l)) begin
        if ((!capture_trigger_mode && capture_request_rise) ||
            (capture_trigger_mode && lane_err_hit[l])) begin
          snap_nxt = SNAP_W'(lane_data_in[l]);
        end
      end
    end
  end

  // Lane fail events are sticky; a new event wins over a write-one clear
  always_comb begin
    logic [DATA_W-1:0] clr;
    logic [DATA_W-1:0] evt;
    clr = '0;
    evt = pass_r & ~pass_nxt;
    if (wr_hit && bus_in.addr == A_IRQ_STAT) begin
      clr = bus_in.wdata;
    end
    irq_stat_nxt = (irq_stat_r & ~clr) | evt;
    irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rd_data_nxt = REG_RST;
    if (bus_in.rd) begin
      case (bus_in.addr)
        A_TEST_EN:  rd_data_nxt = test_en_r;
        A_CTRL:     rd_data_nxt = ctrl_r;
        A_THR_LO:   rd_data_nxt = thr_r[0*DATA_W +: DATA_W];
        A_THR_MID:  rd_data_nxt = thr_r[1*DATA_W +: DATA_W];
        A_THR_HI:   rd_data_nxt = thr_r[2*DATA_W +: DATA_W];
        A_CNT_LO:   rd_data_nxt = count_sel[0*DATA_W +: DATA_W];
        A_CNT_MID:  rd_data_nxt = count_sel[1*DATA_W +: DATA_W];
        A_CNT_HI:   rd_data_nxt = count_sel[2*DATA_W +: DATA_W];
        A_PASS:     rd_data_nxt = pass_r;
        A_CAP:      rd_data_nxt = cap_r;
        A_IRQ_STAT: rd_data_nxt = irq_stat_r;
        A_IRQ_MASK: rd_data_nxt = irq_mask_r;
        default: begin
          for (int k = 0; k < SNAP_N; k++) begin
            if (bus_in.addr == A_SNAP0 + ADDR_W'(k)) begin
              rd_data_nxt = snap_r[k*DATA_W +: DATA_W];
            end
          end
        end
      endcase
    end
  end

  // Register stage for all groups
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      test_en_r   <= REG_RST;
      ctrl_r      <= REG_RST;
      thr_r       <= '0;
      cap_r       <= REG_RST;
      irq_stat_r  <= REG_RST;
      irq_mask_r  <= REG_RST;
      state_r     <= ST_IDLE;
      prev_r      <= '0;
      pass_r      <= PASS_RST;
      snap_r      <= '0;
      rd_data_out <= REG_RST;
      irq_out     <= 1'b0;
      for (int l = 0; l < LANES; l++) begin
        cnt_r[l] <= '0;
      end
    end else begin
      test_en_r   <= test_en_nxt;
      ctrl_r      <= ctrl_nxt;
      thr_r       <= thr_nxt;
      cap_r       <= cap_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      state_r     <= state_nxt;
      prev_r      <= prev_nxt;
      pass_r      <= pass_nxt;
      snap_r      <= snap_nxt;
      rd_data_out <= rd_data_nxt;
      irq_out     <= irq_nxt;
      for (int l = 0; l < LANES; l++) begin
        cnt_r[l] <= cnt_nxt[l];
      end
    end
  end
endmodule

//--- test/lane_ber_checker_asserts.sv
// Register port checks for lane_ber_checker.
// Assumes one clock and a master with one-cycle strobes.
`timescale 1ns/1ps
module lane_ber_checker_asserts import ber_pkg::*; #(
  parameter int LANES  = 8,
  parameter int WORD_W = 40
) (
  input wire logic                         clk_in,
  input wire logic                         rst_n_in,
  input wire ber_pkg::bus_req_t            bus_in,
  input wire logic [LANES-1:0][WORD_W-1:0] lane_data_in,
  input wire logic [ber_pkg::DATA_W-1:0]   rd_data_out,
  input wire logic                         irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [4:0] cap_q;
  logic       grab;
  logic       ok_r;
  logic [7:0] snap_r;
  // The design acts on the stored lane and mode, not on the byte being written
  assign grab = bus_in.wr && bus_in.addr == A_CAP && bus_in.wdata[0] && cap_q[1:0] == 2'h0;
  // Shadow of the last manual capture; error-trigger mode voids it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cap_q <= '0;
      ok_r  <= 1'b0;
    end else if (bus_in.wr && bus_in.addr == A_CAP) begin
      cap_q <= bus_in.wdata[4:0];
      ok_r  <= !bus_in.wdata[1] && (ok_r || grab);
      if (grab) snap_r <= lane_data_in[cap_q[4:2]][7:0];
    end
  end
  // A write, an idle cycle, then a read of the same place
  sequence s_wr(a);
    bus_in.wr && bus_in.addr == a ##1 !bus_in.wr;
  endsequence
  property p_back(a, m);
    s_wr(a) ##1 bus_in.rd && bus_in.addr == a |=> rd_data_out == ($past(bus_in.wdata, 3) & m);
  endproperty
  a_rd_idle: assert property (!$past(bus_in.rd) |-> rd_data_out == '0)
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property (bus_in.rd && !(bus_in.addr inside {[A_TEST_EN:A_IRQ_MASK]})
    |=> rd_data_out == '0) else $error("unmapped read not zero");
  a_clear_pass: assert property (bus_in.wr && bus_in.addr == A_CTRL && bus_in.wdata[0] ##1 !bus_in.wr
    ##1 bus_in.rd && bus_in.addr == A_PASS |=> rd_data_out == PASS_RST) else $error("clear kept a fail");
  a_thr_back: assert property (p_back(A_THR_HI, 8'hFF))
    else $error("threshold byte lost");
  a_ctrl_back: assert property (p_back(A_CTRL, CTRL_WMASK))
    else $error("control readback wrong");
  a_cap_back: assert property (p_back(A_CAP, CAP_WMASK))
    else $error("capture control readback wrong");
  a_mask_quiet: assert property (bus_in.wr && bus_in.addr == A_IRQ_MASK && bus_in.wdata == '0 ##1 !bus_in.wr
    |=> !irq_out) else $error("masked interrupt still high");
  a_snap_manual: assert property (bus_in.rd && bus_in.addr == A_SNAP0 && ok_r
    |=> rd_data_out == $past(snap_r)) else $error("manual snapshot wrong");
endmodule
bind lane_ber_checker lane_ber_checker_asserts #(.LANES(LANES), .WORD_W(WORD_W)) u_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .bus_in(bus_in), .lane_data_in(lane_data_in), .rd_data_out(rd_data_out), .irq_out(irq_out));

//--- test/lane_prbs_source.sv
// Lane transmitter model: pseudo-random words on eight lanes.
// Assumes words are taken on clk_in; flip_in corrupts bit 0 of a lane.
`timescale 1ns/1ps
module lane_prbs_source import ber_pkg::*; #(
  parameter int LANES  = 8,
  parameter int WORD_W = 40
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  input  wire ber_pkg::pattern_t            pat_in,
  input  wire logic [LANES-1:0]             flip_in,
  output logic      [LANES-1:0][WORD_W-1:0] lane_data_out
);
  logic [3:0][WORD_W-1:0] hist_r;
  // Next word of the stream; the unused code falls back to the shortest taps
  function automatic logic [WORD_W-1:0] step(input logic [WORD_W-1:0] w, input pattern_t p);
    logic [2*WORD_W-1:0] s;
    int ta;
    int tb;
    ta = (p == PAT_15) ? TAP15_A : (p == PAT_31) ? TAP31_A : TAP7_A;
    tb = (p == PAT_15) ? TAP15_B : (p == PAT_31) ? TAP31_B : TAP7_B;
    s = {w, w};
    for (int i = WORD_W; i < 2 * WORD_W; i++) s[i] = s[i - ta] ^ s[i - tb];
    return s[2*WORD_W-1:WORD_W];
  endfunction
  // Three old words kept: sums of shifted streams obey the same recurrence
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) hist_r <= {4{WORD_W'(40'hA5_0F3C_96E1)}};
    else hist_r <= {hist_r[2:0], step(hist_r[0], pat_in)};
  end
  // Lanes differ by which old words they mix in, so lane selects are visible
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      lane_data_out[l] = hist_r[0] ^ WORD_W'(flip_in[l]);
      for (int h = 1; h < 4; h++) if (l[h-1]) lane_data_out[l] ^= hist_r[h];
    end
  end
endmodule

//--- test/lane_ber_checker_tb_top.sv
// Bench for lane_ber_checker: register tasks and the test sequence.
// Assumes the lane source model on the lanes and the bound checker.
`timescale 1ns/1ps
module lane_ber_checker_tb_top;
  import ber_pkg::*;
  logic             clk_in = 1'b0;
  logic             rst_n_in = 1'b0;
  bus_req_t         bus = '0;
  pattern_t         pat = PAT_7;
  logic [7:0]       flip = '0;
  logic [7:0][39:0] lanes;
  logic [7:0][39:0] held;
  logic [7:0]       rd_data;
  logic             irq;
  logic [39:0]      word;
  int               k;
  int               miscompares = 0;
  int               tests_run = 0;
  always #10 clk_in = ~clk_in;
  lane_prbs_source src (.clk_in(clk_in), .rst_n_in(rst_n_in), .pat_in(pat), .flip_in(flip), .lane_data_out(lanes));
  lane_ber_checker dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .lane_data_in(lanes),
    .rd_data_out(rd_data), .irq_out(irq));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  // Write; the lane words of the taking edge are kept for capture checks
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk_in) held = lanes;
    @(posedge clk_in) bus.wr <= 1'b0;
  endtask
  // Read and compare in the one cycle where the data stand
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk_in) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in) bus.rd <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  task automatic rd_snap(input logic [39:0] w);
    for (int i = 0; i < 5; i++) rd(A_SNAP0 + 10'(i), w[8*i+:8]);
  endtask
  // One corrupted word on lane n; word holds what the design samples
  task automatic inject(input int n);
    @(posedge clk_in) flip <= 8'(1 << n);
    @(negedge clk_in) word = lanes[n];
    @(posedge clk_in) flip <= '0;
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset values; the read-only pass register ignores a write, an unmapped place reads zero
    wr(A_PASS, 8'h00);
    rd(A_PASS, PASS_RST);
    for (int a = 0; a < 6; a++) rd(A_THR_LO + 10'(a), 8'h00);
    rd(10'h314, 8'h00);
    for (int a = 0; a < 3; a++) begin
      wr(A_THR_LO + 10'(a), 8'hA5 ^ 8'(a));
      rd(A_THR_LO + 10'(a), 8'hA5 ^ 8'(a));
    end
    wr(A_CTRL, 8'hFF);
    rd(A_CTRL, 8'h7F);
    wr(A_CAP, 8'hFF);
    rd(A_CAP, 8'h1F);
    // Manual capture of every lane on a request edge
    for (int j = 0; j < 8; j++) begin
      wr(A_CAP, 8'(j << 2));
      wr(A_CAP, 8'(j << 2) | 8'h01);
      rd_snap(held[j]);
    end
    wr(A_TEST_EN, 8'h01);
    for (int a = 0; a < 3; a++) wr(A_THR_LO + 10'(a), (a == 0) ? 8'h02 : 8'h00);
    // Each of the three patterns: one bad bit gives three errors, above a threshold of two; PAT_NONE gives none
    for (int p = 0; p < 4; p++) begin
      k = 2 * p + 1;
      @(posedge clk_in) pat <= pattern_t'(p);
      wr(A_IRQ_MASK, (p == 1) ? 8'h00 : 8'hFF);
      wr(A_CAP, 8'(k << 2) | 8'h02);
      wr(A_CTRL, 8'(k << 4) | 8'(p << 2) | 8'h01);
      wr(A_CTRL, 8'(k << 4) | 8'(p << 2) | 8'h02);
      repeat (4) @(posedge clk_in);
      inject(k);
      repeat (2) @(posedge clk_in);
      for (int s = 0; s < 8; s++) begin
        wr(A_CTRL, 8'(s << 4) | 8'(p << 2) | 8'h02);
        rd(A_CNT_LO, (s == k && p < 3) ? 8'h03 : 8'h00);
      end
      rd(A_PASS, (p < 3) ? ~8'(1 << k) : 8'hFF);
      chk(irq, p != 1 && p < 3);
      if (p < 3) rd_snap(word);
      wr(A_IRQ_STAT, 8'hFF);
      rd(A_IRQ_STAT, 8'h00);
      chk(irq, 1'b0);
      wr(A_CTRL, 8'(k << 4) | 8'(p << 2));
      inject(k);
      rd(A_CNT_LO, (p < 3) ? 8'h03 : 8'h00);
    end
    // A failing run first, so that the clear has something to undo
    @(posedge clk_in) pat <= PAT_7;
    wr(A_CTRL, 8'h72);
    repeat (4) @(posedge clk_in);
    inject(7);
    rd(A_CNT_LO, 8'h03);
    rd(A_PASS, 8'h7F);
    chk(irq, 1'b1);
    wr(A_CTRL, 8'h71);
    rd(A_PASS, PASS_RST);
    rd(A_CNT_LO, 8'h00);
    // Checkers gated off: a bad bit is not counted
    wr(A_TEST_EN, 8'h00);
    wr(A_CTRL, 8'h32);
    repeat (4) @(posedge clk_in);
    inject(3);
    rd(A_CNT_LO, 8'h00);
    tally_and_finish;
  end
  // Cuts a hang short, well past the normal run length
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    tally_and_finish;
  end
endmodule
